// ### common/swa_defs.svh
// constants of the single-wire authenticator link: command codes, memory map, timing
// Behaviour
// - 64-bit id: family, serial, check byte
// - check byte covers family and serial
// - check polynomial x^8 + x^5 + x^4 + 1
// - generator cleared, family lsb shifted first
// - shifting check byte too leaves zero
// - all bytes travel lsb first
// - master sends identifier command before functions
// - functions open only after identifier command
// - overdrive commands switch device to fast slots
// - identifier addresses device on shared line
// - memory in one linear address space
// - user memory spans 0000h to 0017h
// - unprogrammed user memory reads zero
// - programming writes aligned 4-byte blocks
// - written block locked against later writes
// - pin only pulls low or releases
// - 33h sends family, serial, check byte
// - 55h plus id selects only matching device
// - F0h search: bit, complement, master bit
// - fast mode held until 480us reset
`ifndef SWA_DEFS_SVH
`define SWA_DEFS_SVH

`define SWA_CLK_NS          10
`define SWA_CYC_MIN(t)      (((t) + `SWA_CLK_NS - 1) / `SWA_CLK_NS)
`define SWA_CYC_MAX(t)      ((t) / `SWA_CLK_NS)

`define SWA_CMD_READ_ID     8'h33
`define SWA_CMD_MATCH       8'h55
`define SWA_CMD_SEARCH      8'hF0
`define SWA_CMD_SKIP        8'hCC
`define SWA_CMD_RESUME      8'hA5
`define SWA_CMD_FAST_SKIP   8'h3C
`define SWA_CMD_FAST_MATCH  8'h69
`define SWA_FN_READ         8'hAA
`define SWA_FN_WRITE_BLK    8'h5A

`define SWA_CRC_POLY        8'h8C
`define SWA_MEM_BYTES       24
`define SWA_MEM_LAST        8'h17

// device side times in ns
`define SWA_T_RST_STD_NS    480000
`define SWA_T_RST_FAST_NS   48000
`define SWA_T_PDH_STD_NS    30000
`define SWA_T_PDH_FAST_NS   3000
`define SWA_T_PDL_STD_NS    120000
`define SWA_T_PDL_FAST_NS   12000
`define SWA_T_SMP_STD_NS    30000
`define SWA_T_SMP_FAST_NS   3000
`define SWA_T_HOLD_STD_NS   30000
`define SWA_T_HOLD_FAST_NS  4000

// master side times in ns
`define SWA_T_MRST_STD_NS   500000
`define SWA_T_MRST_FAST_NS  50000
`define SWA_T_MPS_STD_NS    70000
`define SWA_T_MPS_FAST_NS   8000
`define SWA_T_MREC_STD_NS   480000
`define SWA_T_MREC_FAST_NS  48000
`define SWA_T_W1_STD_NS     6000
`define SWA_T_W1_FAST_NS    1000
`define SWA_T_W0_STD_NS     60000
`define SWA_T_W0_FAST_NS    7000
`define SWA_T_MRS_STD_NS    12000
`define SWA_T_MRS_FAST_NS   1500
`define SWA_T_SLOT_STD_NS   70000
`define SWA_T_SLOT_FAST_NS  10000

`endif

// ### common/swa_pkg.sv
// types of the single-wire authenticator link
package swa_pkg;
  typedef enum logic [9:0] {
    DS_IDLE  = 10'h001,
    DS_PRES  = 10'h002,
    DS_ROM   = 10'h004,
    DS_RDID  = 10'h008,
    DS_MATCH = 10'h010,
    DS_SRCH  = 10'h020,
    DS_FCMD  = 10'h040,
    DS_FADDR = 10'h080,
    DS_FREAD = 10'h100,
    DS_FWR   = 10'h200
  } swa_dev_st_e;

  typedef enum logic [3:0] {
    MS_IDLE  = 4'h1,
    MS_RLOW  = 4'h2,
    MS_RWAIT = 4'h4,
    MS_SLOT  = 4'h8
  } swa_mst_st_e;

  typedef enum logic [2:0] {
    OP_RESET = 3'h0,
    OP_WBYTE = 3'h1,
    OP_RBYTE = 3'h2,
    OP_WBIT  = 3'h3,
    OP_RBIT  = 3'h4
  } swa_op_e;

  typedef logic [16:0] swa_tcnt_t;
endpackage

// ### common/swa_if.sv
`timescale 1ns/100ps
// single-wire line joining the device end and the bus master end
interface swa_if;
  logic line;
  logic dev_o;
  logic dev_oe;
  logic mst_o;
  logic mst_oe;

  // wired-and with pull-up: the line is low only where someone drives low
  assign line = !((dev_oe && !dev_o) || (mst_oe && !mst_o));

  modport dev (input line, output dev_o, output dev_oe);
  modport mst (input line, output mst_o, output mst_oe);
endinterface

// ### core/swa_crc8.sv
`timescale 1ns/100ps
// serial check-byte generator shared by both ends
`include "swa_defs.svh"
module swa_crc8 (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       clr,
  input  wire logic       en,
  input  wire logic       din,
  output logic      [7:0] crc
);
  logic fb;

  assign fb = crc[0] ^ din;

  always_ff @(posedge mclk) begin
    if (srst || clr) begin
      crc <= 8'h00;
    end else if (en) begin
      crc <= {1'b0, crc[7:1]} ^ (fb ? `SWA_CRC_POLY : 8'h00);
    end
  end
endmodule

// ### core/swa_dev.sv
`timescale 1ns/100ps
// device end: identifier, network commands, fast mode and otp user memory
`include "swa_defs.svh"
module swa_dev #(
  parameter logic [7:0]  FAMILY       = 8'h3A,            // arbitrary value
  parameter logic [47:0] SERIAL       = 48'h0000_1234_5678, // arbitrary value
  parameter int          RST_STD_CYC  = `SWA_CYC_MIN(`SWA_T_RST_STD_NS),
  parameter int          RST_FAST_CYC = `SWA_CYC_MIN(`SWA_T_RST_FAST_NS),
  parameter int          PDL_STD_CYC  = `SWA_CYC_MIN(`SWA_T_PDL_STD_NS)
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  swa_if.dev                        bus,
  output logic                      fast_speed_flag,
  output logic                      resume_ok,
  output swa_pkg::swa_dev_st_e      state,
  output logic                [5:0] blk_locked
);
  import swa_pkg::*;

  localparam int PDH_STD_CYC   = `SWA_CYC_MIN(`SWA_T_PDH_STD_NS);
  localparam int PDH_FAST_CYC  = `SWA_CYC_MIN(`SWA_T_PDH_FAST_NS);
  localparam int PDL_FAST_CYC  = `SWA_CYC_MIN(`SWA_T_PDL_FAST_NS);
  localparam int SMP_STD_CYC   = `SWA_CYC_MIN(`SWA_T_SMP_STD_NS);
  localparam int SMP_FAST_CYC  = `SWA_CYC_MIN(`SWA_T_SMP_FAST_NS);
  localparam int HOLD_STD_CYC  = `SWA_CYC_MAX(`SWA_T_HOLD_STD_NS);
  localparam int HOLD_FAST_CYC = `SWA_CYC_MAX(`SWA_T_HOLD_FAST_NS);

  swa_dev_st_e state_r;
  logic [2:0]  sync_r;
  logic        line_r;
  logic        line_d_r;
  logic        fall;
  logic        rise;
  logic        rst_ev;
  logic        smp_ev;
  logic        slot_on;
  logic        tx_bit;
  logic        od_r;
  logic        od_go;
  logic        drv_r;
  logic        pres_drv_r;
  logic        prs_done;
  logic        rc_r;
  logic        mok_r;
  logic        fn_wr_r;
  logic        wr_go;
  swa_tcnt_t   tcnt_r;
  swa_tcnt_t   prs_r;
  swa_tcnt_t   t_pdh;
  swa_tcnt_t   t_pend;
  logic [6:0]  bcnt_r;
  logic [1:0]  phase_r;
  logic [7:0]  sh_r;
  logic [7:0]  cmd_w;
  logic [7:0]  addr_r;
  logic [7:0]  rd_byte;
  logic [31:0] wbuf_r;
  logic [31:0] wdat_w;
  logic [7:0]  mem_r [0:`SWA_MEM_BYTES-1];
  logic [5:0]  prot_r;
  logic [5:0]  ini_r;
  logic [7:0]  crc_w;
  logic [55:0] id56;
  logic [63:0] uid;

  function automatic swa_tcnt_t pick(input logic fast, input int s, input int f);
    return fast ? swa_tcnt_t'(f) : swa_tcnt_t'(s);
  endfunction

  // check byte is derived from the stored fields once after reset
  assign id56 = {SERIAL, FAMILY};
  assign uid  = {crc_w, id56};

  always_ff @(posedge mclk) begin
    if (srst) begin
      ini_r <= 6'h00;
    end else if (ini_r != 6'd56) begin
      ini_r <= ini_r + 6'h01;
    end
  end

  swa_crc8 u_crc (
    .mclk (mclk),
    .srst (srst),
    .clr  (1'b0),
    .en   (ini_r != 6'd56),
    .din  (id56[ini_r]),
    .crc  (crc_w)
  );

  // three-stage input filter: level moves only when stages two and three agree
  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_r   <= 3'h7;
      line_r   <= 1'b1;
      line_d_r <= 1'b1;
    end else begin
      sync_r   <= {sync_r[1:0], bus.line};
      line_d_r <= line_r;
      if (sync_r[1] == sync_r[2]) begin
        line_r <= sync_r[2];
      end
    end
  end

  assign fall = line_d_r && !line_r;
  assign rise = !line_d_r && line_r;

  // time since the last falling edge, saturating
  always_ff @(posedge mclk) begin
    if (srst) begin
      tcnt_r <= 17'h1FFFF;
    end else if (fall) begin
      tcnt_r <= 17'h00000;
    end else if (tcnt_r != 17'h1FFFF) begin
      tcnt_r <= tcnt_r + 17'h00001;
    end
  end

  // in fast mode a short reset suffices; only a long one leaves fast mode
  assign rst_ev = rise && (tcnt_r >= pick(od_r, RST_STD_CYC, RST_FAST_CYC));
  assign slot_on = !(state_r == DS_IDLE || state_r == DS_PRES);
  assign smp_ev = slot_on && (tcnt_r == pick(od_r, SMP_STD_CYC, SMP_FAST_CYC) - 17'h00001);
  assign cmd_w  = {line_r, sh_r[7:1]};
  assign wdat_w = {line_r, wbuf_r[31:1]};
  assign od_go  = smp_ev && state_r == DS_ROM && bcnt_r == 7'h07 && !od_r &&
                  (cmd_w == `SWA_CMD_FAST_SKIP || cmd_w == `SWA_CMD_FAST_MATCH);
  assign wr_go  = smp_ev && !rst_ev && state_r == DS_FWR && bcnt_r == 7'h1F;
  assign rd_byte = (addr_r <= `SWA_MEM_LAST) ? mem_r[addr_r[4:0]] : 8'hFF;

  always_ff @(posedge mclk) begin
    if (srst) begin
      od_r <= 1'b0;
    end else if (rst_ev && tcnt_r >= swa_tcnt_t'(RST_STD_CYC)) begin
      od_r <= 1'b0;
    end else if (od_go) begin
      od_r <= 1'b1;
    end
  end

  always_comb begin
    tx_bit = 1'b1;
    case (state_r)
      DS_RDID:  tx_bit = uid[bcnt_r[5:0]];
      DS_SRCH:  tx_bit = (phase_r == 2'h0) ? uid[bcnt_r[5:0]] :
                         (phase_r == 2'h1) ? !uid[bcnt_r[5:0]] : 1'b1;
      DS_FREAD: tx_bit = rd_byte[bcnt_r[2:0]];
      default:  tx_bit = 1'b1;
    endcase
  end

  // presence pulse timed from the end of the reset pulse
  assign t_pdh    = pick(od_r, PDH_STD_CYC, PDH_FAST_CYC);
  assign t_pend   = t_pdh + pick(od_r, PDL_STD_CYC, PDL_FAST_CYC);
  assign prs_done = state_r == DS_PRES && prs_r == t_pend;

  always_ff @(posedge mclk) begin
    if (srst || rst_ev) begin
      prs_r      <= 17'h00000;
      pres_drv_r <= 1'b0;
    end else if (state_r == DS_PRES) begin
      prs_r      <= prs_r + 17'h00001;
      pres_drv_r <= (prs_r >= t_pdh) && (prs_r < t_pend - 17'h00001);
    end else begin
      pres_drv_r <= 1'b0;
    end
  end

  // a zero is sent by holding the line past the master's sample point
  always_ff @(posedge mclk) begin
    if (srst || rst_ev) begin
      drv_r <= 1'b0;
    end else if (fall && slot_on && !tx_bit) begin
      drv_r <= 1'b1;
    end else if (tcnt_r == pick(od_r, HOLD_STD_CYC, HOLD_FAST_CYC) - 17'h00001) begin
      drv_r <= 1'b0;
    end
  end

  assign bus.dev_o  = 1'b0;
  assign bus.dev_oe = drv_r || pres_drv_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r <= DS_IDLE;
      bcnt_r  <= 7'h00;
      phase_r <= 2'h0;
      sh_r    <= 8'h00;
      mok_r   <= 1'b0;
      rc_r    <= 1'b0;
      fn_wr_r <= 1'b0;
      addr_r  <= 8'h00;
      wbuf_r  <= 32'h0000_0000;
    end else if (rst_ev) begin
      state_r <= DS_PRES;
      bcnt_r  <= 7'h00;
      phase_r <= 2'h0;
    end else if (prs_done) begin
      state_r <= DS_ROM;
    end else if (smp_ev) begin
      bcnt_r <= bcnt_r + 7'h01;
      case (state_r)
        DS_ROM: begin
          sh_r <= cmd_w;
          if (bcnt_r == 7'h07) begin
            bcnt_r <= 7'h00;
            mok_r  <= 1'b1;
            case (cmd_w)
              `SWA_CMD_READ_ID: state_r <= DS_RDID;
              `SWA_CMD_MATCH, `SWA_CMD_FAST_MATCH: begin
                state_r <= DS_MATCH;
                rc_r    <= 1'b0;
              end
              `SWA_CMD_SEARCH: begin
                state_r <= DS_SRCH;
                rc_r    <= 1'b0;
              end
              `SWA_CMD_SKIP, `SWA_CMD_FAST_SKIP: state_r <= DS_FCMD;
              `SWA_CMD_RESUME: state_r <= rc_r ? DS_FCMD : DS_IDLE;
              default: state_r <= DS_IDLE;
            endcase
          end
        end
        DS_RDID: begin
          if (bcnt_r == 7'h3F) begin
            bcnt_r  <= 7'h00;
            state_r <= DS_FCMD;
          end
        end
        DS_MATCH: begin
          if (line_r != uid[bcnt_r[5:0]]) begin
            mok_r <= 1'b0;
          end
          if (bcnt_r == 7'h3F) begin
            bcnt_r <= 7'h00;
            // unmatched devices wait out the rest of the frame for a reset
            if (mok_r && line_r == uid[63]) begin
              state_r <= DS_FCMD;
              rc_r    <= 1'b1;
            end else begin
              state_r <= DS_IDLE;
            end
          end
        end
        DS_SRCH: begin
          bcnt_r <= bcnt_r;
          if (phase_r != 2'h2) begin
            phase_r <= phase_r + 2'h1;
          end else if (line_r != uid[bcnt_r[5:0]]) begin
            state_r <= DS_IDLE;
          end else begin
            phase_r <= 2'h0;
            bcnt_r  <= bcnt_r + 7'h01;
            if (bcnt_r == 7'h3F) begin
              bcnt_r  <= 7'h00;
              state_r <= DS_FCMD;
              rc_r    <= 1'b1;
            end
          end
        end
        DS_FCMD: begin
          sh_r <= cmd_w;
          if (bcnt_r == 7'h07) begin
            bcnt_r  <= 7'h00;
            fn_wr_r <= cmd_w == `SWA_FN_WRITE_BLK;
            state_r <= (cmd_w == `SWA_FN_READ || cmd_w == `SWA_FN_WRITE_BLK) ? DS_FADDR : DS_IDLE;
          end
        end
        DS_FADDR: begin
          sh_r <= cmd_w;
          if (bcnt_r == 7'h07) begin
            bcnt_r  <= 7'h00;
            addr_r  <= cmd_w;
            state_r <= fn_wr_r ? DS_FWR : DS_FREAD;
          end
        end
        DS_FREAD: begin
          if (bcnt_r == 7'h07) begin
            bcnt_r <= 7'h00;
            addr_r <= addr_r + 8'h01;
          end
        end
        DS_FWR: begin
          wbuf_r <= wdat_w;
          if (bcnt_r == 7'h1F) begin
            state_r <= DS_IDLE;
          end
        end
        default: bcnt_r <= 7'h00;
      endcase
    end
  end

  // user memory; cleared on reset to model the factory state
  always_ff @(posedge mclk) begin
    if (srst) begin
      for (int i = 0; i < `SWA_MEM_BYTES; i++) begin
        mem_r[i] <= 8'h00;
      end
      prot_r <= 6'h00;
    end else if (wr_go && addr_r <= `SWA_MEM_LAST && !prot_r[addr_r[4:2]]) begin
      for (int k = 0; k < 4; k++) begin
        mem_r[{addr_r[4:2], k[1:0]}] <= wdat_w[8*k +: 8];
      end
      prot_r[addr_r[4:2]] <= 1'b1;
    end
  end

  assign fast_speed_flag = od_r;
  assign resume_ok       = rc_r;
  assign state           = state_r;
  assign blk_locked      = prot_r;
endmodule

// ### core/swa_mst.sv
`timescale 1ns/100ps
// bus master end: reset, presence detect and bit/byte slots on the single line
`include "swa_defs.svh"
module swa_mst #(
  parameter int MRST_STD_CYC = `SWA_CYC_MIN(`SWA_T_MRST_STD_NS),
  parameter int MREC_STD_CYC = `SWA_CYC_MIN(`SWA_T_MREC_STD_NS),
  parameter int SLOT_STD_CYC = `SWA_CYC_MIN(`SWA_T_SLOT_STD_NS)
) (
  input  wire logic                 mclk,
  input  wire logic                 srst,
  swa_if.mst                        bus,
  input  wire logic                 fast_speed_flag,
  input  wire logic                 req_valid,
  output logic                      req_ready,
  input  wire swa_pkg::swa_op_e     req_op,
  input  wire logic           [7:0] req_data,
  output logic                      rsp_valid,
  output logic                [7:0] rsp_data,
  output logic                      rsp_presence,
  output logic                [7:0] crc_rem
);
  import swa_pkg::*;

  localparam int MRST_FAST_CYC = `SWA_CYC_MIN(`SWA_T_MRST_FAST_NS);
  localparam int MPS_STD_CYC   = `SWA_CYC_MIN(`SWA_T_MPS_STD_NS);
  localparam int MPS_FAST_CYC  = `SWA_CYC_MIN(`SWA_T_MPS_FAST_NS);
  localparam int MREC_FAST_CYC = `SWA_CYC_MIN(`SWA_T_MREC_FAST_NS);
  localparam int W1_STD_CYC    = `SWA_CYC_MIN(`SWA_T_W1_STD_NS);
  localparam int W1_FAST_CYC   = `SWA_CYC_MIN(`SWA_T_W1_FAST_NS);
  localparam int W0_STD_CYC    = `SWA_CYC_MIN(`SWA_T_W0_STD_NS);
  localparam int W0_FAST_CYC   = `SWA_CYC_MIN(`SWA_T_W0_FAST_NS);
  localparam int MRS_STD_CYC   = `SWA_CYC_MAX(`SWA_T_MRS_STD_NS);
  localparam int MRS_FAST_CYC  = `SWA_CYC_MAX(`SWA_T_MRS_FAST_NS);
  localparam int SLOT_FAST_CYC = `SWA_CYC_MIN(`SWA_T_SLOT_FAST_NS);

  swa_mst_st_e state_r;
  swa_op_e     op_r;
  swa_tcnt_t   tmr_r;
  swa_tcnt_t   t_low;
  logic [2:0]  sync_r;
  logic        line_r;
  logic        spd_r;
  logic        rd_op;
  logic        smp;
  logic [7:0]  sh_r;
  logic [7:0]  rd_r;
  logic [3:0]  left_r;

  function automatic swa_tcnt_t pick(input logic fast, input int s, input int f);
    return fast ? swa_tcnt_t'(f) : swa_tcnt_t'(s);
  endfunction

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync_r <= 3'h7;
      line_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], bus.line};
      if (sync_r[1] == sync_r[2]) begin
        line_r <= sync_r[2];
      end
    end
  end

  assign rd_op = op_r == OP_RBYTE || op_r == OP_RBIT;
  assign t_low = (rd_op || sh_r[0]) ? pick(spd_r, W1_STD_CYC, W1_FAST_CYC) : pick(spd_r, W0_STD_CYC, W0_FAST_CYC);
  assign smp   = state_r == MS_SLOT && rd_op && tmr_r == pick(spd_r, MRS_STD_CYC, MRS_FAST_CYC);
  assign req_ready = state_r == MS_IDLE;
  assign bus.mst_o  = 1'b0;
  assign bus.mst_oe = state_r == MS_RLOW || (state_r == MS_SLOT && tmr_r < t_low);

  always_ff @(posedge mclk) begin
    if (srst) begin
      state_r      <= MS_IDLE;
      op_r         <= OP_RESET;
      tmr_r        <= 17'h00000;
      spd_r        <= 1'b0;
      sh_r         <= 8'h00;
      rd_r         <= 8'h00;
      left_r       <= 4'h0;
      rsp_valid    <= 1'b0;
      rsp_data     <= 8'h00;
      rsp_presence <= 1'b0;
    end else begin
      rsp_valid <= 1'b0;
      tmr_r     <= tmr_r + 17'h00001;
      case (state_r)
        MS_IDLE: begin
          tmr_r <= 17'h00000;
          if (req_valid) begin
            op_r    <= req_op;
            sh_r    <= req_data;
            spd_r   <= fast_speed_flag;
            left_r  <= (req_op == OP_WBYTE || req_op == OP_RBYTE) ? 4'h8 : 4'h1;
            state_r <= (req_op == OP_RESET) ? MS_RLOW : MS_SLOT;
          end
        end
        MS_RLOW: begin
          if (tmr_r == pick(spd_r, MRST_STD_CYC, MRST_FAST_CYC) - 17'h00001) begin
            tmr_r   <= 17'h00000;
            state_r <= MS_RWAIT;
          end
        end
        MS_RWAIT: begin
          if (tmr_r == pick(spd_r, MPS_STD_CYC, MPS_FAST_CYC)) begin
            rsp_presence <= !line_r;
          end
          if (tmr_r == pick(spd_r, MREC_STD_CYC, MREC_FAST_CYC) - 17'h00001) begin
            rsp_valid <= 1'b1;
            state_r   <= MS_IDLE;
          end
        end
        MS_SLOT: begin
          if (smp) begin
            rd_r <= {line_r, rd_r[7:1]};
          end
          if (tmr_r == pick(spd_r, SLOT_STD_CYC, SLOT_FAST_CYC) - 17'h00001) begin
            tmr_r  <= 17'h00000;
            sh_r   <= {1'b0, sh_r[7:1]};
            left_r <= left_r - 4'h1;
            if (left_r == 4'h1) begin
              rsp_valid <= 1'b1;
              rsp_data  <= (op_r == OP_RBIT) ? {7'h00, rd_r[7]} : rd_r;
              state_r   <= MS_IDLE;
            end
          end
        end
        default: state_r <= MS_IDLE;
      endcase
    end
  end

  // remainder over every bit read since the last reset; zero after a valid id
  swa_crc8 u_crc (
    .mclk (mclk),
    .srst (srst),
    .clr  (req_valid && req_ready && req_op == OP_RESET),
    .en   (smp),
    .din  (line_r),
    .crc  (crc_rem)
  );
endmodule

// ### dv/swa_link_asserts.sv
// line-level checks between the device end and the master end
`timescale 1ns/100ps
module swa_link_asserts #(
  parameter int RST_STD_CYC = 6500,
  parameter int PDL_STD_CYC = 5000
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic line,
  input wire logic dev_o,
  input wire logic dev_oe,
  input wire logic mst_o,
  input wire logic mst_oe,
  input wire logic fast_speed_flag
);
  localparam int PRES_WAIT = 3100;
  int low_cnt;
  int dev_cnt;
  int pres_cnt;
  int pulse_len;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // length of the current master pull; a long one is a reset pulse
  always_ff @(posedge mclk) begin
    low_cnt <= (srst || !mst_oe) ? 0 : low_cnt + 1;
  end

  always_ff @(posedge mclk) begin
    dev_cnt <= (srst || !dev_oe) ? 0 : dev_cnt + 1;
  end

  // cycles since a long master pull ended; zero when not waiting or once presence shows
  always_ff @(posedge mclk) begin
    if (srst || (dev_oe && !line)) begin
      pres_cnt <= 0;
    end else if ($fell(mst_oe) && low_cnt >= RST_STD_CYC) begin
      pres_cnt <= 1;
    end else if (pres_cnt != 0) begin
      pres_cnt <= pres_cnt + 1;
    end
  end

  // the device only acts on a pull once it is released, so judge by the last finished one
  always_ff @(posedge mclk) begin
    if (srst) begin
      pulse_len <= 0;
    end else if ($fell(mst_oe)) begin
      pulse_len <= low_cnt;
    end
  end

  property p_dev_low_only; !dev_o; endproperty
  a_dev_low_only: assert property (p_dev_low_only) else $error("device drives line high");
  property p_mst_low_only; !mst_o; endproperty
  a_mst_low_only: assert property (p_mst_low_only) else $error("master drives line high");
  property p_quiet_start; $fell(srst) |-> !dev_oe && !mst_oe; endproperty
  a_quiet_start: assert property (p_quiet_start) else $error("line pulled right after reset");
  property p_silent_in_reset; low_cnt > RST_STD_CYC |-> !dev_oe; endproperty
  a_silent_in_reset: assert property (p_silent_in_reset) else $error("device pulls during reset pulse");
  property p_presence;
    pres_cnt == PRES_WAIT |-> dev_oe && !line;
  endproperty
  a_presence: assert property (p_presence) else $error("no presence after reset pulse");
  property p_pull_width;
    $fell(dev_oe) |-> dev_cnt <= 3008 || (dev_cnt >= PDL_STD_CYC - 2 && dev_cnt <= PDL_STD_CYC + 8);
  endproperty
  a_pull_width: assert property (p_pull_width) else $error("device pull of wrong length");
  property p_fast_hold; fast_speed_flag && pulse_len < RST_STD_CYC - 16 |=> fast_speed_flag; endproperty
  a_fast_hold: assert property (p_fast_hold) else $error("fast mode lost without long reset");
  property p_fast_clear; $fell(mst_oe) && low_cnt >= RST_STD_CYC + 16 |-> ##8 !fast_speed_flag; endproperty
  a_fast_clear: assert property (p_fast_clear) else $error("fast mode kept over long reset");
  property p_fast_set; $rose(fast_speed_flag) |-> low_cnt < RST_STD_CYC; endproperty
  a_fast_set: assert property (p_fast_set) else $error("fast mode set during reset");
endmodule

// ### dv/single_wire_id_crc_otp_slave_test.sv
// self-checking bench: device end and master end joined on one line
`timescale 1ns/100ps
module single_wire_id_crc_otp_slave_test;
  import swa_pkg::*;
  localparam logic [7:0]  FAM = 8'hA7;              // arbitrary value
  localparam logic [47:0] SER = 48'h0000_5E1F_C0D2; // arbitrary value
  localparam int          DEV_RST = 6500;
  localparam int          DEV_PDL = 5000;

  logic        mclk;
  logic        srst;
  logic        mfast;
  logic        req_valid;
  logic        req_ready;
  swa_op_e     req_op;
  logic [7:0]  req_data;
  logic        rsp_valid;
  logic [7:0]  rsp_data;
  logic        rsp_presence;
  logic [7:0]  crc_rem;
  logic        dev_fast;
  logic        dev_resume;
  swa_dev_st_e dev_state;
  logic [5:0]  blk_locked;
  logic [7:0]  rd;
  logic [31:0] seed;
  int          failures;
  int          n_compared;

  swa_if bus_if ();
  swa_dev #(.FAMILY(FAM), .SERIAL(SER), .RST_STD_CYC(DEV_RST), .PDL_STD_CYC(DEV_PDL)) u_swa_dev (
    .mclk(mclk), .srst(srst), .bus(bus_if.dev), .fast_speed_flag(dev_fast), .resume_ok(dev_resume),
    .state(dev_state), .blk_locked(blk_locked));
  // shortened standard reset that still stays above the device's long-reset count
  swa_mst #(.MRST_STD_CYC(8000), .MREC_STD_CYC(9000)) u_swa_mst (
    .mclk(mclk), .srst(srst), .bus(bus_if.mst), .fast_speed_flag(mfast), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_data(req_data), .rsp_valid(rsp_valid),
    .rsp_data(rsp_data), .rsp_presence(rsp_presence), .crc_rem(crc_rem));
  swa_link_asserts #(.RST_STD_CYC(DEV_RST), .PDL_STD_CYC(DEV_PDL)) u_swa_link_asserts (
    .mclk(mclk), .srst(srst), .line(bus_if.line), .dev_o(bus_if.dev_o), .dev_oe(bus_if.dev_oe),
    .mst_o(bus_if.mst_o), .mst_oe(bus_if.mst_oe), .fast_speed_flag(dev_fast));

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [7:0] crc_of(input logic [55:0] bits);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 56; i++) begin
      c = bits[i] ^ c[0] ? (c >> 1) ^ 8'h8C : c >> 1;
    end
    return c;
  endfunction

  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // entered just after an edge with the master idle; returns once rsp_valid is seen
  task automatic op(input swa_op_e o, input logic [7:0] d);
    int i;
    req_op = o;
    req_data = d;
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    for (i = 0; i < 100000 && rsp_valid !== 1'b1; i++) begin
      @(posedge mclk);
      #1;
    end
    if (rsp_valid !== 1'b1) begin
      failures++;
      $display("BAD response timeout");
      results();
    end
    rd = rsp_data;
  endtask

  task automatic reset_bus(input logic fast);
    mfast = fast;
    op(OP_RESET, 8'h00);
    check("presence", rsp_presence, 1'b1);
  endtask

  initial begin
    logic [63:0] id;
    logic [39:0] exp;
    logic [31:0] wd;
    srst = 1'b1;
    mfast = 1'b0;
    req_valid = 1'b0;
    req_op = OP_RESET;
    req_data = 8'h00;
    failures = 0;
    n_compared = 0;
    seed = 32'h347E8E16;
    repeat (3) @(posedge mclk);
    #1;
    srst = 1'b0;
    check("state after reset", dev_state, DS_IDLE);
    reset_bus(1'b0);
    op(OP_WBYTE, 8'h3C);
    check("fast after skip", dev_fast, 1'b1);
    $display("test fast_entry done");
    reset_bus(1'b1);
    check("fast over short reset", dev_fast, 1'b1);
    op(OP_WBYTE, 8'h33);
    id = {crc_of({SER, FAM}), SER, FAM};
    for (int k = 0; k < 8; k++) begin
      op(OP_RBYTE, 8'hFF);
      check("id byte", rd, id[8*k+:8]);
    end
    check("check remainder", crc_rem, 8'h00);
    $display("test read_id done");
    reset_bus(1'b1);
    op(OP_WBYTE, 8'hAA);
    check("state after bad command", dev_state, DS_IDLE);
    op(OP_RBYTE, 8'h00);
    check("silent line", rd, 8'hFF);
    $display("test bad_command done");
    reset_bus(1'b1);
    op(OP_WBYTE, 8'hF0);
    op(OP_RBIT, 8'hFF);
    check("search bit", rd, {7'h00, FAM[0]});
    op(OP_RBIT, 8'hFF);
    check("search complement", rd, {7'h00, !FAM[0]});
    // writing the opposite bit must make the device drop out of the search
    op(OP_WBIT, {7'h00, !FAM[0]});
    check("state after search miss", dev_state, DS_IDLE);
    check("resume after search miss", dev_resume, 1'b0);
    $display("test search_miss done");
    seed = lfsr(seed);
    exp = {seed, 8'h00};
    for (int p = 0; p < 2; p++) begin
      wd = p == 0 ? seed : ~seed;
      reset_bus(1'b1);
      op(OP_WBYTE, 8'hCC);
      op(OP_WBYTE, 8'h5A);
      op(OP_WBYTE, 8'h04);
      for (int k = 0; k < 4; k++) begin
        op(OP_WBYTE, wd[8*k+:8]);
      end
      check("locked blocks", blk_locked, 6'h02);
    end
    reset_bus(1'b1);
    op(OP_WBYTE, 8'hCC);
    op(OP_WBYTE, 8'hAA);
    op(OP_WBYTE, 8'h03);
    for (int k = 0; k < 5; k++) begin
      op(OP_RBYTE, 8'hFF);
      check("memory byte", rd, exp[8*k+:8]);
    end
    $display("test otp_block done");
    reset_bus(1'b0);
    check("fast after long reset", dev_fast, 1'b0);
    $display("test fast_exit done");
    results();
  end
endmodule
